// [hdl/dtc_timer_top.sv]
// Dual timer/counter with external interrupt controls and event status
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module dtc_timer_top (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [7:0] rdata,
	input wire logic ext_irq_a_pin,
	input wire logic ext_irq_b_pin,
	input wire logic timer_a_count_pin,
	input wire logic timer_b_count_pin,
	input wire logic [3:0] vector_ack,
	output logic [3:0] int_request,
	output logic irq
);

	// Software visible state
	dtc_pkg::dtc_control_t control;
	dtc_pkg::dtc_mode_t mode_sel;
	logic [7:0] timer_a_count_low;
	logic [7:0] timer_a_count_high;
	logic [7:0] timer_b_count_low;
	logic [7:0] timer_b_count_high;
	logic [3:0] event_status;
	logic [3:0] event_mask;

	// Next values
	dtc_pkg::dtc_control_t next_control;
	logic [7:0] next_ta_low;
	logic [7:0] next_ta_high;
	logic [7:0] next_tb_low;
	logic [7:0] next_tb_high;
	logic [3:0] next_status;
	logic [3:0] next_mask;
	logic [7:0] next_rdata;
	dtc_pkg::dtc_mode_t next_mode;
	logic next_irq;

	// Pin samples and the timer tick divider
	logic [3:0] pin_level;
	logic [3:0] pin_fall;
	logic div_cnt;
	logic div_pulse;

	// Timer enables, ticks and results
	logic ta_enable;
	logic tb_enable;
	logic ta_tick;
	logic tb_tick;
	logic split_tick;
	logic split_mode;
	dtc_pkg::dtc_step_t ta_step;
	dtc_pkg::dtc_step_t tb_step;
	dtc_pkg::dtc_step_t split_step;
	logic ta_ovf;
	logic tb_ovf;
	logic [3:0] events;

	// Register bus decode
	logic wr_control;
	logic wr_mode;
	logic wr_ta_low;
	logic wr_ta_high;
	logic wr_tb_low;
	logic wr_tb_high;
	logic wr_status;
	logic wr_mask;

	// Synchronise all four pins
	dtc_pin_sync #(
		.WIDTH(dtc_pkg::NUM_PINS)
	) u_pin_sync (
		.mclk(mclk),
		.resetn(resetn),
		.pin({timer_b_count_pin, timer_a_count_pin,
			ext_irq_b_pin, ext_irq_a_pin}),
		.level(pin_level),
		.fall(pin_fall)
	);

	// One step of a counter pair in modes 00, 01 and 10
	function automatic dtc_pkg::dtc_step_t count_step(
		input logic [1:0] mode,
		input logic [7:0] low,
		input logic [7:0] high,
		input logic tick
	);
		dtc_pkg::dtc_step_t s;
		s.low = low;
		s.high = high;
		s.ovf = 1'b0;
		if (tick) begin
			case (mode)
				dtc_pkg::MODE_PRESCALED: begin
					// Low five bits prescale the high byte
					s.low[dtc_pkg::PRESCALE_BITS-1:0] =
						low[dtc_pkg::PRESCALE_BITS-1:0] + 5'h01;
					if (&low[dtc_pkg::PRESCALE_BITS-1:0]) begin
						s.high = high + 8'h01;
						s.ovf = &high;
					end
				end
				dtc_pkg::MODE_WIDE: begin
					{s.high, s.low} = {high, low} + 16'h0001;
					s.ovf = &{high, low};
				end
				dtc_pkg::MODE_RELOAD: begin
					// Reload from high byte on wrap
					s.low = (&low) ? high : low + 8'h01;
					s.ovf = &low;
				end
				default: begin
					s.low = low;
				end
			endcase
		end
		return s;
	endfunction

	// Timer tick divider, one pulse every two clocks
	assign div_pulse = div_cnt;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			div_cnt <= 1'b0;
		end else begin
			div_cnt <= ~div_cnt;
		end
	end

	// Enables: run bit, optionally gated by interrupt pin high
	assign ta_enable = control.timer_a_run &
		(~mode_sel.timer_a_pin_gating |
		pin_level[dtc_pkg::PIN_EXT_A]);
	assign tb_enable = control.timer_b_run &
		(~mode_sel.timer_b_pin_gating |
		pin_level[dtc_pkg::PIN_EXT_B]);

	// Tick source: divided clock or count pin falling edge
	assign ta_tick = ta_enable & (mode_sel.timer_a_source_sel ?
		pin_fall[dtc_pkg::PIN_COUNT_A] : div_pulse);
	assign tb_tick = tb_enable & (mode_sel.timer_b_source_sel ?
		pin_fall[dtc_pkg::PIN_COUNT_B] : div_pulse);

	// Split mode: high byte of timer A times on timer B run bit
	assign split_mode =
		(mode_sel.timer_a_mode_field == dtc_pkg::MODE_SPLIT_STOP);
	assign split_tick = split_mode & control.timer_b_run &
		div_pulse;

	// Counter steps; timer B mode 11 holds inside the function
	assign ta_step = count_step(mode_sel.timer_a_mode_field,
		timer_a_count_low, timer_a_count_high, ta_tick);
	assign tb_step = count_step(mode_sel.timer_b_mode_field,
		timer_b_count_low, timer_b_count_high, tb_tick);

	// Split mode low and high bytes as two 8-bit counters
	assign split_step.low = timer_a_count_low + {7'h00, ta_tick};
	assign split_step.high = timer_a_count_high + {7'h00, split_tick};
	assign split_step.ovf = split_tick & (&timer_a_count_high);

	// Overflow sources for the two flags
	assign ta_ovf = split_mode ? (ta_tick & (&timer_a_count_low)) :
		ta_step.ovf;
	assign tb_ovf = split_mode ? split_step.ovf : tb_step.ovf;

	// Events: interrupt pin by edge or low level, and overflows
	assign events[dtc_pkg::EV_EXT_A] = control.ext_irq_a_trigger_sel ?
		pin_fall[dtc_pkg::PIN_EXT_A] :
		~pin_level[dtc_pkg::PIN_EXT_A];
	assign events[dtc_pkg::EV_EXT_B] = control.ext_irq_b_trigger_sel ?
		pin_fall[dtc_pkg::PIN_EXT_B] :
		~pin_level[dtc_pkg::PIN_EXT_B];
	assign events[dtc_pkg::EV_TIMER_A] = ta_ovf;
	assign events[dtc_pkg::EV_TIMER_B] = tb_ovf;

	// Address decode for writes
	assign wr_control = wr_stb & (addr == dtc_pkg::OFF_TIMER_CONTROL);
	assign wr_mode = wr_stb & (addr == dtc_pkg::OFF_TIMER_MODE_SELECT);
	assign wr_ta_low = wr_stb & (addr == dtc_pkg::OFF_TIMER_A_COUNT_LOW);
	assign wr_ta_high = wr_stb & (addr == dtc_pkg::OFF_TIMER_A_COUNT_HIGH);
	assign wr_tb_low = wr_stb & (addr == dtc_pkg::OFF_TIMER_B_COUNT_LOW);
	assign wr_tb_high = wr_stb & (addr == dtc_pkg::OFF_TIMER_B_COUNT_HIGH);
	assign wr_status = wr_stb & (addr == dtc_pkg::OFF_EVENT_STATUS);
	assign wr_mask = wr_stb & (addr == dtc_pkg::OFF_EVENT_MASK);

	// Counter bytes: a software write beats the count
	assign next_ta_low = wr_ta_low ? wdata :
		(split_mode ? split_step.low : ta_step.low);
	assign next_ta_high = wr_ta_high ? wdata :
		(split_mode ? split_step.high : ta_step.high);
	assign next_tb_low = wr_tb_low ? wdata : tb_step.low;
	assign next_tb_high = wr_tb_high ? wdata : tb_step.high;

	// Control flags: write, then vector clear, then hardware set wins
	always_comb begin
		next_control = wr_control ? dtc_pkg::dtc_control_t'(wdata) : control;
		if (vector_ack[dtc_pkg::EV_EXT_A]) begin
			next_control.ext_irq_a_flag = 1'b0;
		end
		if (vector_ack[dtc_pkg::EV_TIMER_A]) begin
			next_control.timer_a_overflow_flag = 1'b0;
		end
		if (vector_ack[dtc_pkg::EV_EXT_B]) begin
			next_control.ext_irq_b_flag = 1'b0;
		end
		if (vector_ack[dtc_pkg::EV_TIMER_B]) begin
			next_control.timer_b_overflow_flag = 1'b0;
		end
		if (events[dtc_pkg::EV_EXT_A]) begin
			next_control.ext_irq_a_flag = 1'b1;
		end
		if (events[dtc_pkg::EV_TIMER_A]) begin
			next_control.timer_a_overflow_flag = 1'b1;
		end
		if (events[dtc_pkg::EV_EXT_B]) begin
			next_control.ext_irq_b_flag = 1'b1;
		end
		if (events[dtc_pkg::EV_TIMER_B]) begin
			next_control.timer_b_overflow_flag = 1'b1;
		end
	end

	// Sticky status: write one to clear, new event wins
	assign next_status = (event_status & ~(wr_status ? wdata[3:0] : 4'h0)) |
		events;
	assign next_mask = wr_mask ? wdata[3:0] : event_mask;

	// Mode register write and interrupt level from next values
	assign next_mode = wr_mode ? dtc_pkg::dtc_mode_t'(wdata) : mode_sel;
	assign next_irq = |(next_status & next_mask);

	// Read selection, zero for unmapped addresses
	always_comb begin
		case (addr)
			dtc_pkg::OFF_TIMER_CONTROL: next_rdata = control;
			dtc_pkg::OFF_TIMER_MODE_SELECT: next_rdata = mode_sel;
			dtc_pkg::OFF_TIMER_A_COUNT_LOW: next_rdata = timer_a_count_low;
			dtc_pkg::OFF_TIMER_B_COUNT_LOW: next_rdata = timer_b_count_low;
			dtc_pkg::OFF_TIMER_A_COUNT_HIGH: next_rdata = timer_a_count_high;
			dtc_pkg::OFF_TIMER_B_COUNT_HIGH: next_rdata = timer_b_count_high;
			dtc_pkg::OFF_EVENT_STATUS: next_rdata = {4'h0, event_status};
			dtc_pkg::OFF_EVENT_MASK: next_rdata = {4'h0, event_mask};
			default: next_rdata = 8'h00;
		endcase
	end

	// Flags are the requests to the core
	assign int_request = {control.timer_b_overflow_flag,
		control.ext_irq_b_flag, control.timer_a_overflow_flag,
		control.ext_irq_a_flag};

	// Control register
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			control <= dtc_pkg::dtc_control_t'(dtc_pkg::RST_TIMER_CONTROL);
		end else begin
			control <= next_control;
		end
	end

	// Mode select register
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			mode_sel <= dtc_pkg::dtc_mode_t'(dtc_pkg::RST_TIMER_MODE_SELECT);
		end else begin
			mode_sel <= next_mode;
		end
	end

	// Timer A low byte
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			timer_a_count_low <= dtc_pkg::RST_COUNT;
		end else begin
			timer_a_count_low <= next_ta_low;
		end
	end

	// Timer A high byte
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			timer_a_count_high <= dtc_pkg::RST_COUNT;
		end else begin
			timer_a_count_high <= next_ta_high;
		end
	end

	// Timer B low byte
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			timer_b_count_low <= dtc_pkg::RST_COUNT;
		end else begin
			timer_b_count_low <= next_tb_low;
		end
	end

	// Timer B high byte
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			timer_b_count_high <= dtc_pkg::RST_COUNT;
		end else begin
			timer_b_count_high <= next_tb_high;
		end
	end

	// Sticky event status
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			event_status <= dtc_pkg::RST_EVENTS;
		end else begin
			event_status <= next_status;
		end
	end

	// Event mask
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			event_mask <= dtc_pkg::RST_EVENTS;
		end else begin
			event_mask <= next_mask;
		end
	end

	// Interrupt line, rises with the status bit
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq;
		end
	end

	// Read data, one cycle after the strobe only
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rdata <= 8'h00;
		end else begin
			rdata <= rd_stb ? next_rdata : 8'h00;
		end
	end

endmodule

`default_nettype wire

// [hdl/dtc_pkg.sv]
// Constants, field layouts and carrier types for the dual timer/counter
// Functional notes
// - Timer B overflow sets control bit 7; cleared when its vector is taken.
// - Timer A overflow sets control bit 5; cleared when its vector is taken.
// - Timer B counts only while run bit 6 is one.
// - Timer A counts only while run bit 4 is one; in mode 11 its high byte runs on bit 6.
// - Falling edge on interrupt pin B sets bit 3; vector clears it.
// - Falling edge on interrupt pin A sets bit 1; vector clears it.
// - Bit 2 selects pin B trigger: zero low level, one falling edge.
// - Bit 0 selects pin A trigger: zero low level, one falling edge.
// - Timer B gating bit 7: when set, also needs pin B high.
// - Timer A gating bit 3: when set, also needs pin A high.
// - Timer B source bit 6: every two clocks, or count pin falling edges.
// - Timer A source bit 2: every two clocks, or count pin falling edges.
// - Timer B mode 00: 5-bit low prescaler feeds 8-bit high counter.
// - Timer B modes: 01 sixteen bit, 10 low reload from high, 11 stopped.
// - Timer A modes: 00 prescaled 8-bit, 01 sixteen bit.
// - Timer A mode 10: low byte counts, reloads from high byte on overflow.
// - Timer A mode 11: low own counter; high uses timer B run and flag.
package dtc_pkg;

	// Register offsets
	localparam logic [7:0] OFF_TIMER_CONTROL = 8'h88;
	localparam logic [7:0] OFF_TIMER_MODE_SELECT = 8'h89;
	localparam logic [7:0] OFF_TIMER_A_COUNT_LOW = 8'h8a;
	localparam logic [7:0] OFF_TIMER_B_COUNT_LOW = 8'h8b;
	localparam logic [7:0] OFF_TIMER_A_COUNT_HIGH = 8'h8c;
	localparam logic [7:0] OFF_TIMER_B_COUNT_HIGH = 8'h8d;
	localparam logic [7:0] OFF_EVENT_STATUS = 8'ha0;
	localparam logic [7:0] OFF_EVENT_MASK = 8'ha1;

	// Reset values
	localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
	localparam logic [7:0] RST_TIMER_MODE_SELECT = 8'h00;
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [3:0] RST_EVENTS = 4'h0;

	// Mode field encodings
	localparam logic [1:0] MODE_PRESCALED = 2'b00;
	localparam logic [1:0] MODE_WIDE = 2'b01;
	localparam logic [1:0] MODE_RELOAD = 2'b10;
	localparam logic [1:0] MODE_SPLIT_STOP = 2'b11;

	// Prescaler width in mode 00 and clocks per timer tick
	localparam int PRESCALE_BITS = 5;
	localparam int TICK_DIV = 2;

	// Event indices in status, mask, vector acknowledge and requests
	localparam int EV_EXT_A = 0;
	localparam int EV_TIMER_A = 1;
	localparam int EV_EXT_B = 2;
	localparam int EV_TIMER_B = 3;
	localparam int NUM_EVENTS = 4;

	// Synchronised pin indices
	localparam int PIN_EXT_A = 0;
	localparam int PIN_EXT_B = 1;
	localparam int PIN_COUNT_A = 2;
	localparam int PIN_COUNT_B = 3;
	localparam int NUM_PINS = 4;

	// Timer control register, bit 7 down to bit 0
	typedef struct packed {
		logic timer_b_overflow_flag;
		logic timer_b_run;
		logic timer_a_overflow_flag;
		logic timer_a_run;
		logic ext_irq_b_flag;
		logic ext_irq_b_trigger_sel;
		logic ext_irq_a_flag;
		logic ext_irq_a_trigger_sel;
	} dtc_control_t;

	// Timer mode select register, bit 7 down to bit 0
	typedef struct packed {
		logic timer_b_pin_gating;
		logic timer_b_source_sel;
		logic [1:0] timer_b_mode_field;
		logic timer_a_pin_gating;
		logic timer_a_source_sel;
		logic [1:0] timer_a_mode_field;
	} dtc_mode_t;

	// One timer's count pair plus its overflow
	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
		logic ovf;
	} dtc_step_t;

endpackage

// [hdl/dtc_pin_sync.sv]
// Two-stage pin synchroniser with falling edge detection per pin
`timescale 1ns/10ps
`default_nettype none

module dtc_pin_sync #(
	parameter int WIDTH = 4
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] fall
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_pin
			logic meta;
			logic stable;
			logic prev;

			// Two flops, then one more sample for the edge
			always_ff @(posedge mclk) begin
				if (!resetn) begin
					meta <= 1'b1;
					stable <= 1'b1;
					prev <= 1'b1;
				end else begin
					meta <= pin[i];
					stable <= meta;
					prev <= stable;
				end
			end

			assign level[i] = stable;
			assign fall[i] = prev & ~stable; // One pulse per edge
		end
	endgenerate

endmodule

`default_nettype wire

// [verif/dtc_pin_model.sv]
// Far side model driving the interrupt, gate and count pins
`timescale 1ns/10ps
`default_nettype none

module dtc_pin_model (
	input wire logic mclk,
	input wire logic [3:0] drive,
	output var logic [3:0] pins
);
	// Pins idle high and follow the bench command one clock later
	initial pins = 4'hf;
	always @(posedge mclk) begin
		pins <= drive;
	end
endmodule

`default_nettype wire

// [verif/dtc_timer_asserts.sv]
// Concurrent checks on the dual timer/counter ports
`timescale 1ns/10ps
`default_nettype none

module dtc_timer_asserts (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [7:0] rdata,
	input wire logic ext_irq_a_pin,
	input wire logic ext_irq_b_pin,
	input wire logic timer_a_count_pin,
	input wire logic timer_b_count_pin,
	input wire logic [3:0] vector_ack,
	input wire logic [3:0] int_request,
	input wire logic irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	// Pin seen high, then low for four samples
	sequence s_fell(p);
		p ##1 !p [*4];
	endsequence
	property pf(p, f);
		s_fell(p) |-> ##[0:3] f;
	endproperty
	// A flag only drops after its vector or a register write
	property pc(int b);
		$fell(int_request[b]) |-> $past(vector_ack[b]) ||
			$past(wr_stb && addr == 8'h88);
	endproperty

	chk_ext_a_set: assert property (pf(ext_irq_a_pin, int_request[0]))
		else $error("ext A flag missing after fall");
	chk_ext_b_set: assert property (pf(ext_irq_b_pin, int_request[2]))
		else $error("ext B flag missing after fall");
	chk_ext_a_clr: assert property (pc(0))
		else $error("ext A flag dropped without cause");
	chk_tmr_a_clr: assert property (pc(1))
		else $error("timer A flag dropped without cause");
	chk_ext_b_clr: assert property (pc(2))
		else $error("ext B flag dropped without cause");
	chk_tmr_b_clr: assert property (pc(3))
		else $error("timer B flag dropped without cause");
	chk_rd_idle: assert property (!rd_stb |=> rdata == 8'h00)
		else $error("read data outside read slot");
	chk_rst_quiet: assert property (disable iff (1'b0)
		!resetn |=> rdata == 8'h00 && !irq && int_request == 4'h0)
		else $error("outputs active in reset");
	chk_irq_cause: assert property ($rose(irq) && !$past(wr_stb)
		|-> int_request != 4'h0)
		else $error("irq rose with no event flag");
endmodule

bind dtc_timer_top dtc_timer_asserts i_chk (
	.mclk, .resetn, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
	.ext_irq_a_pin, .ext_irq_b_pin, .timer_a_count_pin,
	.timer_b_count_pin, .vector_ack, .int_request, .irq
);

`default_nettype wire

// [verif/test_dual_timer_counter_ext_int.sv]
// Self-checking bench for the dual timer/counter block
`timescale 1ns/10ps
`default_nettype none

module test_dual_timer_counter_ext_int;
	// Mode, control, low addr, loads, low and high ranges, flags, pins
	typedef struct packed {
		logic [7:0] md, ct, ra, hi, lo, l0, l1, h0, h1;
		logic [3:0] rm, re, dr;
	} dtc_row_t;
	dtc_row_t rows [10] = '{
		84'h01_10_8a_ff_fd_01_03_00_00_2_2_f,
		84'h00_40_8b_ff_fe_e2_e4_00_00_8_8_f,
		84'h02_10_8a_f0_fe_f2_f4_f0_f0_2_2_f,
		84'h10_40_8b_00_00_04_06_00_00_8_0_f,
		84'h20_40_8b_f0_fe_f2_f4_f0_f0_8_8_f,
		84'h30_40_8b_12_34_34_34_12_12_8_0_f,
		84'h03_40_8a_fe_00_00_00_02_04_8_8_f,
		84'h09_10_8a_00_00_00_00_00_00_2_0_e,
		84'h01_10_8a_00_00_04_06_00_00_2_0_e,
		84'h90_40_8b_00_00_00_00_00_00_8_0_d
	};
	logic [7:0] regs [8] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d,
		8'ha0, 8'ha1};
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [3:0] vector_ack = 4'h0;
	logic [3:0] drive = 4'hf;
	logic [3:0] pins;
	logic [3:0] req;
	logic [7:0] rdata;
	logic [3:0] int_request;
	logic irq;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cyc = 0;

	dtc_timer_top i_dut (
		.mclk, .resetn, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
		.ext_irq_a_pin(pins[0]), .ext_irq_b_pin(pins[1]),
		.timer_a_count_pin(pins[2]), .timer_b_count_pin(pins[3]),
		.vector_ack, .int_request, .irq
	);
	dtc_pin_model i_pins (.mclk, .drive, .pins);

	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Range compare; an unknown never matches
	task automatic chk(logic [7:0] got, logic [7:0] lo, logic [7:0] hi);
		samples_checked++;
		if ((^got) === 1'bx || got < lo || got > hi) begin
			n_mismatch++;
			$display("[ERR] %0t got %h want %h..%h", $time, got, lo, hi);
		end
	endtask
	task automatic cb(logic got, logic exp);
		chk({7'h00, got}, {7'h00, exp}, {7'h00, exp});
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
	endtask
	task automatic rc(logic [7:0] a, logic [7:0] lo, logic [7:0] hi);
		@(posedge mclk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		@(negedge mclk);
		chk(rdata, lo, hi);
	endtask
	// Load, run for ten clocks, stop, then read counts and flags
	task automatic scen(dtc_row_t r);
		@(posedge mclk);
		drive <= r.dr;
		wr(8'h89, r.md);
		wr(r.ra + 8'h02, r.hi);
		wr(r.ra, r.lo);
		wr(8'h88, r.ct);
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		req = int_request;
		wr(8'h88, 8'h00);
		drive <= 4'hf;
		rc(r.ra, r.l0, r.l1);
		rc(r.ra + 8'h02, r.h0, r.h1);
		chk({4'h0, req & r.rm}, {4'h0, r.re}, {4'h0, r.re});
	endtask

	initial begin
		forever #4 mclk = ~mclk;
	end
	// Cuts a hung run short
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 3000) begin
			n_mismatch++;
			$display("[ERR] %0t run did not finish", $time);
			stop_test();
		end
	end

	initial begin
		repeat (10) @(posedge mclk);
		resetn <= 1'b1;
		foreach (regs[i]) rc(regs[i], 8'h00, 8'h00);
		rc(8'h8e, 8'h00, 8'h00);
		wr(8'ha1, 8'hff);
		rc(8'ha1, 8'h0f, 8'h0f);
		foreach (rows[i]) scen(rows[i]);
		// Three falling edges on both count pins
		wr(8'h89, 8'h55);
		wr(8'h8a, 8'h00);
		wr(8'h8b, 8'h00);
		wr(8'h88, 8'h50);
		repeat (3) begin
			@(posedge mclk) drive <= 4'h3;
			repeat (3) @(posedge mclk);
			drive <= 4'hf;
			repeat (3) @(posedge mclk);
		end
		repeat (4) @(posedge mclk);
		rc(8'h8a, 8'h03, 8'h03);
		rc(8'h8b, 8'h03, 8'h03);
		wr(8'ha0, 8'h0f);
		wr(8'ha1, 8'h05);
		// Edge trigger, mask, status clear, vector, then level trigger
		for (int i = 0; i < 2; i++) begin
			wr(8'h88, i ? 8'h04 : 8'h01);
			@(posedge mclk) drive <= i ? 4'hd : 4'he;
			repeat (6) @(negedge mclk);
			cb(int_request[2 * i], 1'b1);
			cb(irq, 1'b1);
			wr(8'ha1, 8'h00);
			repeat (2) @(negedge mclk);
			cb(irq, 1'b0);
			wr(8'ha0, 8'h05);
			wr(8'ha1, 8'h05);
			repeat (2) @(negedge mclk);
			cb(irq, 1'b0);
			@(posedge mclk) vector_ack <= i ? 4'h4 : 4'h1;
			@(posedge mclk) vector_ack <= 4'h0;
			repeat (3) @(negedge mclk);
			cb(int_request[2 * i], 1'b0);
			wr(8'h88, 8'h00);
			repeat (3) @(negedge mclk);
			cb(int_request[2 * i], 1'b1);
			@(posedge mclk) drive <= 4'hf;
			repeat (6) @(posedge mclk);
			wr(8'ha0, 8'h0f);
		end
		// Software sets both timer flags, vectors clear them
		wr(8'h88, 8'ha0);
		@(negedge mclk);
		cb(int_request[1] & int_request[3], 1'b1);
		@(posedge mclk) vector_ack <= 4'ha;
		@(posedge mclk) vector_ack <= 4'h0;
		@(negedge mclk);
		cb(int_request[1] | int_request[3], 1'b0);
		// Mid-run reset returns every register to zero
		wr(8'h8c, 8'h5a);
		rc(8'h8c, 8'h5a, 8'h5a);
		@(posedge mclk) resetn <= 1'b0;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		foreach (regs[i]) rc(regs[i], 8'h00, 8'h00);
		stop_test();
	end
endmodule

`default_nettype wire
